// ---- tb/ibsf_bus_peer.sv ----
// Model of another master on the shared two-wire bus.
`timescale 1ns/100ps
module ibsf_bus_peer
(
   // Wire levels seen by the block.
   output logic scl_line,
   output logic sda_line
);
   // ********
   // Open-drain drivers
   // ********
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;
   // A released line floats up to its pull-up, never to the last level.
   assign scl_line = !scl_low;
   assign sda_line = !sda_low;
   // Start: data falls with the clock high, then the clock is held low.
   task automatic gen_start();
      sda_low = 1'b1;
      #32 scl_low = 1'b1;
      #32;
   endtask : gen_start
   // Stop: data rises with the clock high; clock stands still afterwards.
   task automatic gen_stop();
      scl_low = 1'b1;
      #32 sda_low = 1'b1;
      #32 scl_low = 1'b0;
      #32 sda_low = 1'b0;
      #32;
   endtask : gen_stop
endmodule : ibsf_bus_peer

// ---- tb/ibsf_monitor.sv ----
// Assertion checker for the bus status and start flag block.
`timescale 1ns/100ps
module ibsf_monitor
   import ibsf_pkg::*;
#(
   parameter int unsigned ADDR_W = IBSF_ADDR_W
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register bus.
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Pins and outputs.
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic start_issue,
   input wire logic operation_enable,
   input wire logic irq
);
   // ********
   // Properties
   // ********
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Control write taking effect; lane 0 must be enabled or it is ignored.
   wire logic ctl_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
      && avs_address == ADDR_W'(IBSF_IDX_CTRL);
   property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("request not answered");
   property p_short; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_short: assert property (p_short) else $error("answer too long");
   property p_byte; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
   a_byte: assert property (p_byte) else $error("upper read bits set");
   property p_pulse; start_issue |=> !start_issue; endproperty
   a_pulse: assert property (p_pulse) else $error("issue pulse too long");
   property p_off; start_issue |-> operation_enable; endproperty
   a_off: assert property (p_off) else $error("issue while disabled");
   property p_gap; ctl_wr && avs_writedata[1] |=> !start_issue; endproperty
   a_gap: assert property (p_gap) else $error("issue too early");
   property p_en; ctl_wr && avs_writedata[7] |-> ##[1:2] operation_enable; endproperty
   a_en: assert property (p_en) else $error("enable not taken");
   property p_dis; ctl_wr && !avs_writedata[7] |-> ##[1:2] !operation_enable; endproperty
   a_dis: assert property (p_dis) else $error("disable not taken");
   property p_rst; $fell(sys_rst) |-> avs_readdata == 32'h0 && !start_issue && !irq; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   c_issue: cover property (start_issue);
   c_irq: cover property (irq);
   c_en: cover property (ctl_wr && avs_writedata[7]);
endmodule : ibsf_monitor

bind ibsf_top ibsf_monitor #(.ADDR_W(ADDR_W)) u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in),
   .sda_in(sda_in), .start_issue(start_issue), .operation_enable(operation_enable), .irq(irq));

// ---- tb/ibsf_top_tb.sv ----
// Self-checking testbench of the bus status and start flag block.
`timescale 1ns/100ps
module ibsf_top_tb
   import ibsf_pkg::*;
;
   // ********
   // Signals and instances
   // ********
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, start_issue, operation_enable, irq, scl_line, sda_line;
   int err_count = 0;
   int samples_checked = 0;
   int issue_cnt = 0;
   ibsf_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scl_in(scl_line), .sda_in(sda_line),
      .start_issue(start_issue), .operation_enable(operation_enable), .irq(irq));
   ibsf_bus_peer u_peer (.scl_line(scl_line), .sda_line(sda_line));
   // Clock at 200 MHz.
   initial begin
      forever #2.5 ref_clk = !ref_clk;
   end
   // Issue pulses are counted so a missed or extra one shows.
   always @(posedge ref_clk) begin
      if (start_issue === 1'b1) issue_cnt <= issue_cnt + 1;
   end
   // ********
   // Tasks
   // ********
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk
   // One bus cycle; the request is held until waitrequest is seen low.
   // Only the watchdog ends a wait that never gets its answer.
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
      input logic [3:0] be, output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= idx;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      avs_byteenable <= be;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      chk("answer_wait", 32'd2, n);
   endtask : bus
   task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
      logic [31:0] d;
      bus(1'b1, idx, wd, 4'hF, d);
   endtask : wr
   task automatic rc(input string name, input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, idx, 8'h00, 4'hF, d);
      chk(name, exp, d);
   endtask : rc
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : idle
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   // The whole sequence takes some 2 us; fifty times that means a hang.
   initial begin
      #100000;
      err_count++;
      finish_test();
   end
   // ********
   // Tests
   // ********
   initial begin
      logic [31:0] d;
      idle(10);
      sys_rst <= 1'b0;
      rc("flag_reset", IBSF_IDX_FLAG, 32'h00);
      rc("unmapped", 6'h3F, 32'h00);
      $display("test reset done");
      // Byte and single-bit access while operation is off.
      bus(1'b1, IBSF_IDX_FLAG, 8'h3C, 4'hE, d);
      rc("flag_lane", IBSF_IDX_FLAG, 32'h00);
      wr(IBSF_IDX_FLAG, 8'hFF);
      rc("flag_ro", IBSF_IDX_FLAG, 32'h3F);
      wr(IBSF_IDX_BITOP, 8'h05);
      wr(IBSF_IDX_BITOP, 8'h0E);
      rc("flag_bit", IBSF_IDX_FLAG, 32'h1F);
      rc("bitop", IBSF_IDX_BITOP, 32'h06);
      wr(IBSF_IDX_FLAG, 8'h00);
      $display("test access done");
      // Enable with initial start off; reservation holds the request.
      wr(IBSF_IDX_IRQ_EN, 8'h01);
      wr(IBSF_IDX_CTRL, 8'h80);
      idle(4);
      rc("busy_enable", IBSF_IDX_FLAG, 32'h40);
      chk("op_enable", 32'h1, {31'h0, operation_enable});
      wr(IBSF_IDX_FLAG, 8'h03);
      rc("locked", IBSF_IDX_FLAG, 32'h40);
      wr(IBSF_IDX_CTRL, 8'h82);
      idle(20);
      chk("no_issue", 32'd0, issue_cnt);
      u_peer.gen_stop();
      idle(20);
      chk("issue_stop", 32'd1, issue_cnt);
      rc("released", IBSF_IDX_FLAG, 32'h00);
      $display("test reservation done");
      // Start seen on the bus raises, masks and clears the interrupt.
      wr(IBSF_IDX_IRQ_CLR, 8'h0F);
      u_peer.gen_start();
      idle(20);
      rc("busy_start", IBSF_IDX_FLAG, 32'h40);
      chk("irq_set", 32'h1, {31'h0, irq});
      rc("irq_stat", IBSF_IDX_IRQ_STAT, 32'h01);
      wr(IBSF_IDX_IRQ_EN, 8'h00);
      idle(3);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(IBSF_IDX_IRQ_CLR, 8'h01);
      rc("irq_clear", IBSF_IDX_IRQ_STAT, 32'h00);
      u_peer.gen_stop();
      idle(20);
      $display("test interrupt done");
      // Initial start on, reservation off: issue, drop and clear.
      wr(IBSF_IDX_CTRL, 8'h00);
      wr(IBSF_IDX_FLAG, 8'h03);
      wr(IBSF_IDX_CTRL, 8'h80);
      idle(4);
      rc("free_enable", IBSF_IDX_FLAG, 32'h03);
      wr(IBSF_IDX_CTRL, 8'h82);
      idle(20);
      chk("first_issue", 32'd2, issue_cnt);
      u_peer.gen_start();
      idle(20);
      rc("init_clear", IBSF_IDX_FLAG, 32'h41);
      wr(IBSF_IDX_CTRL, 8'h82);
      idle(20);
      rc("dropped", IBSF_IDX_FLAG, 32'hC1);
      u_peer.gen_stop();
      idle(20);
      wr(IBSF_IDX_CTRL, 8'h82);
      idle(20);
      rc("drop_clear", IBSF_IDX_FLAG, 32'h01);
      chk("issue_again", 32'd3, issue_cnt);
      $display("test drop done");
      // A reset in mid-run must clear flags that software had set.
      sys_rst <= 1'b1;
      idle(4);
      sys_rst <= 1'b0;
      rc("flag_rerun", IBSF_IDX_FLAG, 32'h00);
      chk("op_rerun", 32'h0, {31'h0, operation_enable});
      $display("test rerun reset done");
      finish_test();
   end
endmodule : ibsf_top_tb

// ---- verilog/ibsf_cond_detect.sv ----
// Pin synchroniser and start/stop condition detector for the two-wire bus.
`timescale 1ns/100ps
module ibsf_cond_detect
   import ibsf_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Raw bus pins.
   input wire ibsf_line_s line_pin,
   // Detected conditions.
   output ibsf_cond_s cond
);

   // ****************************************************************
   // Three-stage synchroniser.
   // ****************************************************************
   ibsf_line_s s1_q;
   ibsf_line_s s2_q;
   ibsf_line_s s3_q;
   ibsf_line_s lvl_q;
   ibsf_line_s lvl_d;

   // Stage one is read only by stage two.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
      end else begin
         s1_q <= line_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A level is accepted only when stages two and three agree, which
   // rejects a sample taken while the pin was still settling.
   always_comb begin
      lvl_d = lvl_q;
      if (s2_q.scl == s3_q.scl) begin
         lvl_d.scl = s3_q.scl;
      end
      if (s2_q.sda == s3_q.sda) begin
         lvl_d.sda = s3_q.sda;
      end
   end

   // Accepted levels; an idle bus rests high.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         lvl_q <= '1;
      end else begin
         lvl_q <= lvl_d;
      end
   end

   // ****************************************************************
   // Condition detection.
   // ****************************************************************
   // Data moving while the clock line stays high marks start or stop.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cond <= '0;
      end else begin
         cond.start <= lvl_q.scl & lvl_d.scl & lvl_q.sda & ~lvl_d.sda;
         cond.stop <= lvl_q.scl & lvl_d.scl & ~lvl_q.sda & lvl_d.sda;
      end
   end

endmodule : ibsf_cond_detect

// ---- verilog/ibsf_pkg.sv ----
// Package of constants and types for the bus status and start flag block.
package ibsf_pkg;

   // ****************************************************************
   // Register map, word indices on the register bus.
   // ****************************************************************
   localparam int unsigned IBSF_ADDR_W = 6;
   localparam logic [5:0] IBSF_IDX_CTRL = 6'h00;
   localparam logic [5:0] IBSF_IDX_FLAG = 6'h0A;
   localparam logic [5:0] IBSF_IDX_BITOP = 6'h0B;
   localparam logic [5:0] IBSF_IDX_IRQ_STAT = 6'h10;
   localparam logic [5:0] IBSF_IDX_IRQ_EN = 6'h11;
   localparam logic [5:0] IBSF_IDX_IRQ_CLR = 6'h12;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int unsigned IBSF_FLAG_DROP = 7;
   localparam int unsigned IBSF_FLAG_BUSY = 6;
   localparam int unsigned IBSF_FLAG_SPARE_HI = 5;
   localparam int unsigned IBSF_FLAG_SPARE_LO = 2;
   localparam int unsigned IBSF_FLAG_INIT = 1;
   localparam int unsigned IBSF_FLAG_RSV = 0;
   localparam int unsigned IBSF_CTRL_OPEN = 7;
   localparam int unsigned IBSF_CTRL_START = 1;
   localparam int unsigned IBSF_BITOP_VAL = 3;

   // ****************************************************************
   // Interrupt events and reset values.
   // ****************************************************************
   localparam int unsigned IBSF_EV_N = 4;
   localparam int unsigned IBSF_EV_START = 0;
   localparam int unsigned IBSF_EV_STOP = 1;
   localparam int unsigned IBSF_EV_DROP = 2;
   localparam int unsigned IBSF_EV_ISSUE = 3;
   localparam logic [7:0] IBSF_FLAG_RST = 8'h00;
   localparam logic [7:0] IBSF_CTRL_RST = 8'h00;
   localparam logic [3:0] IBSF_EV_RST = 4'h0;

   // Bus pin levels, raw at the pins or after synchronisation.
   typedef struct packed {
      logic scl;
      logic sda;
   } ibsf_line_s;

   // Detected bus conditions, one-cycle pulses.
   typedef struct packed {
      logic start;
      logic stop;
   } ibsf_cond_s;

   // Start request handler states.
   typedef enum logic [1:0] {
      IBSF_REQ_IDLE = 2'b01,
      IBSF_REQ_PEND = 2'b10
   } ibsf_req_e;

endpackage : ibsf_pkg

// ---- verilog/ibsf_top.sv ----
// Bus status and start flag register block with its register bus slave.
//
// Contract
// - Flag register resets to 00 hex on every reset.
// - Flag register is accessible as a whole byte or one bit.
// - Bits 7 and 6 are read-only; writes there do nothing.
// - Reservation and initial-start bits take software writes only while operation is off.
// - Dropped-start flag clears on a start request write or reset.
// - Reservation off: an unissuable start is dropped and the flag is set.
// - Busy flag sets on start, clears on stop or reset.
// - Enabling operation with initial-start bit 0 sets the busy flag.
// - Initial-start bit 0: no start is generated until a stop is seen.
// - Initial-start bit 1: a start may be generated without a stop.
// - Initial-start bit is set by software, cleared by start or reset.
// - Reservation-disable bit 0 enables reservation, 1 disables it.
// - Reservation-disable bit changes only by software or reset.
// - Initial-start bit 1 shows the bus released right after enable.
`timescale 1ns/100ps
module ibsf_top
   import ibsf_pkg::*;
#(
   parameter int unsigned ADDR_W = IBSF_ADDR_W
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Avalon-MM register slave.
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Two-wire bus pins, input side only.
   input wire logic scl_in,
   input wire logic sda_in,
   // Towards the start condition generator.
   output logic start_issue,
   output logic operation_enable,
   // Interrupt.
   output logic irq
);

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   // Address match, used by both the read and write decoders.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
      hit = (a == ADDR_W'(idx));
   endfunction : hit

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   ibsf_cond_s cond;
   ibsf_line_s line_pin;
   ibsf_req_e req_state_q;
   ibsf_req_e req_state_d;
   logic [7:0] flag_wr;
   logic [7:0] flag_rd;
   logic [7:0] ctrl_rd;
   logic [IBSF_EV_N-1:0] ev;
   logic [IBSF_EV_N-1:0] ev_stat_q;
   logic [IBSF_EV_N-1:0] ev_en_q;
   logic [2:0] bitop_sel_q;
   logic wr_go;
   logic wr_flag_byte;
   logic wr_flag_bit;
   logic wr_ctrl;
   logic wr_start;
   logic enable_rise;
   logic can_issue;
   logic drop_now;
   logic issue_now;
   logic drop_flag_q;
   logic busy_flag_q;
   logic wait_stop_q;
   logic init_start_q;
   logic rsv_dis_q;
   logic [3:0] spare_q;
   logic start_req_q;
   logic open_q;

   // ****************************************************************
   // Condition detection.
   // ****************************************************************
   assign line_pin.scl = scl_in;
   assign line_pin.sda = sda_in;

   ibsf_cond_detect u_cond (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .line_pin(line_pin),
      .cond(cond)
   );

   // ****************************************************************
   // Register bus slave.
   // ****************************************************************
   // Every access waits exactly one cycle, so wait request is a flop.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // A write takes effect at the edge where wait request is seen low.
   assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign wr_flag_byte = wr_go & hit(avs_address, IBSF_IDX_FLAG);
   assign wr_flag_bit = wr_go & hit(avs_address, IBSF_IDX_BITOP);
   assign wr_ctrl = wr_go & hit(avs_address, IBSF_IDX_CTRL);
   assign wr_start = wr_ctrl & avs_writedata[IBSF_CTRL_START];

   // One-bit writes alter only the selected bit of the flag register.
   always_comb begin
      flag_wr = flag_rd;
      if (wr_flag_byte) begin
         flag_wr = avs_writedata[7:0];
      end else if (wr_flag_bit) begin
         flag_wr[avs_writedata[2:0]] = avs_writedata[IBSF_BITOP_VAL];
      end
   end

   // Register images as software reads them.
   assign flag_rd = {drop_flag_q, busy_flag_q, spare_q, init_start_q, rsv_dis_q};
   assign ctrl_rd = 8'({open_q, 5'h00, start_req_q, 1'b0});

   // Bit selector of the one-bit port; a read returns that bit in bit 3 with the selector below it.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bitop_sel_q <= 3'h0;
      end else if (wr_flag_bit) begin
         bitop_sel_q <= avs_writedata[2:0];
      end
   end

   // Read data is loaded together with the answer; unmapped reads give 0.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & avs_waitrequest) begin
         if (hit(avs_address, IBSF_IDX_FLAG)) begin
            avs_readdata <= {24'h000000, flag_rd};
         end else if (hit(avs_address, IBSF_IDX_BITOP)) begin
            avs_readdata <= {28'h0000000, flag_rd[bitop_sel_q], bitop_sel_q};
         end else if (hit(avs_address, IBSF_IDX_CTRL)) begin
            avs_readdata <= {24'h000000, ctrl_rd};
         end else if (hit(avs_address, IBSF_IDX_IRQ_STAT)) begin
            avs_readdata <= {28'h0000000, ev_stat_q};
         end else if (hit(avs_address, IBSF_IDX_IRQ_EN)) begin
            avs_readdata <= {28'h0000000, ev_en_q};
         end else begin
            avs_readdata <= 32'h00000000;
         end
      end
   end

   // ****************************************************************
   // Control register.
   // ****************************************************************
   // Operation enable is plain software state.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         open_q <= IBSF_CTRL_RST[IBSF_CTRL_OPEN];
      end else if (wr_ctrl) begin
         open_q <= avs_writedata[IBSF_CTRL_OPEN];
      end
   end

   assign enable_rise = wr_ctrl & avs_writedata[IBSF_CTRL_OPEN] & ~open_q;

   // ****************************************************************
   // Start request handling.
   // ****************************************************************
   // A start may go out only on a free bus and not while the first stop
   // after enabling is still awaited.
   assign can_issue = ~busy_flag_q & ~wait_stop_q;
   assign issue_now = (req_state_q == IBSF_REQ_PEND) & open_q & can_issue;
   assign drop_now = (req_state_q == IBSF_REQ_PEND) & open_q & ~can_issue
      & rsv_dis_q;

   // With reservation enabled the request waits for the bus to free up.
   always_comb begin
      req_state_d = req_state_q;
      unique case (req_state_q)
         IBSF_REQ_IDLE: begin
            if (wr_start & open_q) begin
               req_state_d = IBSF_REQ_PEND;
            end
         end
         IBSF_REQ_PEND: begin
            if (~open_q | issue_now | drop_now) begin
               req_state_d = IBSF_REQ_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         req_state_q <= IBSF_REQ_IDLE;
      end else begin
         req_state_q <= req_state_d;
      end
   end

   // Request bit as software sees it follows the handler state.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         start_req_q <= IBSF_CTRL_RST[IBSF_CTRL_START];
      end else begin
         start_req_q <= (req_state_d == IBSF_REQ_PEND);
      end
   end

   // Issue pulse to the condition generator.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         start_issue <= 1'b0;
      end else begin
         start_issue <= issue_now;
      end
   end

   // ****************************************************************
   // Flag register.
   // ****************************************************************
   // Dropped-start flag; a drop outranks a clear in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         drop_flag_q <= IBSF_FLAG_RST[IBSF_FLAG_DROP];
      end else if (drop_now) begin
         drop_flag_q <= 1'b1;
      end else if (wr_start) begin
         drop_flag_q <= 1'b0;
      end
   end

   // Busy flag. Flag register writes never reach it.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy_flag_q <= IBSF_FLAG_RST[IBSF_FLAG_BUSY];
      end else if (enable_rise) begin
         busy_flag_q <= ~init_start_q;
      end else if (open_q & cond.start) begin
         busy_flag_q <= 1'b1;
      end else if (open_q & cond.stop) begin
         busy_flag_q <= 1'b0;
      end
   end

   // The first stop after enabling unlocks start generation.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wait_stop_q <= 1'b0;
      end else if (enable_rise) begin
         wait_stop_q <= ~init_start_q;
      end else if (~open_q | cond.stop) begin
         wait_stop_q <= 1'b0;
      end
   end

   // Initial-start bit: software sets it while stopped, a start clears it.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         init_start_q <= IBSF_FLAG_RST[IBSF_FLAG_INIT];
      end else if (open_q & cond.start) begin
         init_start_q <= 1'b0;
      end else if ((wr_flag_byte | wr_flag_bit) & ~open_q) begin
         init_start_q <= flag_wr[IBSF_FLAG_INIT];
      end
   end

   // Reservation-disable bit: no bus event touches it.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rsv_dis_q <= IBSF_FLAG_RST[IBSF_FLAG_RSV];
      end else if ((wr_flag_byte | wr_flag_bit) & ~open_q) begin
         rsv_dis_q <= flag_wr[IBSF_FLAG_RSV];
      end
   end

   // Spare bits are kept only so software reads back what it wrote.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         spare_q <= IBSF_FLAG_RST[IBSF_FLAG_SPARE_HI:IBSF_FLAG_SPARE_LO];
      end else if (wr_flag_byte | wr_flag_bit) begin
         spare_q <= flag_wr[IBSF_FLAG_SPARE_HI:IBSF_FLAG_SPARE_LO];
      end
   end

   // ****************************************************************
   // Interrupts.
   // ****************************************************************
   assign ev[IBSF_EV_START] = open_q & cond.start;
   assign ev[IBSF_EV_STOP] = open_q & cond.stop;
   assign ev[IBSF_EV_DROP] = drop_now;
   assign ev[IBSF_EV_ISSUE] = issue_now;

   // Sticky status bits; a new event beats a clear in the same cycle.
   for (genvar i = 0; i < IBSF_EV_N; i++) begin : g_ev
      always_ff @(posedge ref_clk) begin
         if (sys_rst) begin
            ev_stat_q[i] <= IBSF_EV_RST[i];
         end else if (ev[i]) begin
            ev_stat_q[i] <= 1'b1;
         end else if (wr_go & hit(avs_address, IBSF_IDX_IRQ_CLR) & avs_writedata[i]) begin
            ev_stat_q[i] <= 1'b0;
         end
      end
   end

   // Enable mask.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ev_en_q <= IBSF_EV_RST;
      end else if (wr_go & hit(avs_address, IBSF_IDX_IRQ_EN)) begin
         ev_en_q <= avs_writedata[IBSF_EV_N-1:0];
      end
   end

   // Level interrupt, one cycle behind the status bits it reflects.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_stat_q & ev_en_q);
      end
   end

   // Registered copy of the enable for the rest of the controller.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         operation_enable <= 1'b0;
      end else begin
         operation_enable <= open_q;
      end
   end

endmodule : ibsf_top
